// >>> core/plbf_fabric.sv
// Programmable logic fabric: eight logic blocks, routing matrix,
// term allocators, macrocells and pin cells, configured over APB.
// Assumes pins and clock pins are synchronous to clk_sys.
//
// Operation
// - Eight blocks joined by routing from 64 two-way and 2 input pins.
// - Four clock pins serve as clock, gate or plain data input.
// - Block has 64 terms, allocator, 16 macrocells, 8 pin cells.
// - Routing hands 26 selected signals to every block's array.
// - Each block has two enable terms, one reset and one preset term.
// - All storage of a block is cleared or set together.
// - Each block feeds back 16 macrocell and 8 pin signals.
// - Buried feedback reaches only own or paired block.
// - Allocator shares 64 terms, at most 16 per macrocell.
// - Macrocell k draws only clusters k-1 to k+2 within 0..15.
// - Macrocell is registered, latched or plain, polarity set, always fed back.
// - A register is D type or T type.
// - Each storage cell picks one of four clock pins.
// - Registers capture on rising edge of the chosen pin.
// - Latch follows while gate low, holds while gate high.
// - Block reset term forces zero, preset term forces one.
// - Buried cell acts like pin cell, or captures a pin input.
// - Pin driver always on, off, or one of two enable terms.
// - Pin stays a routing input when its macrocell is buried.
`timescale 1ns/10ps
module plbf_fabric
    import plbf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NIO-1:0] io_in,
    output logic [NIO-1:0] io_out,
    output logic [NIO-1:0] io_oe,
    input wire logic [NDED-1:0] ded_in,
    input wire logic [NCLK-1:0] clk_pin
);

    // ------------------------------------------------------------
    // Configuration memories
    // ------------------------------------------------------------
    logic [NIN-1:0] term_true_ff [NBLK][NTERM];
    logic [NIN-1:0] term_comp_ff [NBLK][NTERM];
    logic [7:0] route_ff [NBLK][NIN];
    plbf_mccfg_t mccfg_ff [NBLK][NMC];
    logic [1:0] steer_ff [NBLK][NCLU];

    plbf_state_t state_ff;
    plbf_state_t nxt_state;

    logic [NSRC-1:0] src;
    logic [NIN-1:0] blk_in [NBLK];
    logic [NTERM-1:0] pt [NBLK];
    logic [NMC-1:0] mc_sum [NBLK];

    logic hit_term;
    logic hit_route;
    logic hit_mccfg;
    logic hit_steer;
    logic hit_ro;
    logic hit_mcq;
    logic hit_pin_lo;
    logic hit_pin_hi;
    logic hit_pin_misc;
    logic [31:0] rd_data;
    logic wr_take;

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign io_out = state_ff.io_out;
    assign io_oe = state_ff.io_oe;

    // Write lands only on the edge where the slave shows ready
    assign wr_take = psel & penable & state_ff.pready & pwrite;

    // ------------------------------------------------------------
    // Register decode and read mux
    // ------------------------------------------------------------
    // Map: terms, routing, cell setup, cluster steering, then
    // read-only cell state, pin levels and clock pins.
    // Term words hold one bit per routed input; a term with both
    // masks empty reads low, so a blank device drives nothing.
    always_comb
    begin
        hit_term = (paddr[15:13] == ADR_TERM[15:13])
            && (int'(paddr[9:3]) < NTERM);
        hit_route = (paddr[15:10] == ADR_ROUTE[15:10])
            && (int'(paddr[6:2]) < NIN);
        hit_mccfg = (paddr[15:9] == ADR_MCCFG[15:9]);
        hit_steer = (paddr[15:9] == ADR_STEER[15:9]);
        hit_mcq = (paddr[15:5] == ADR_MCQ[15:5]);
        hit_pin_lo = (paddr[15:2] == ADR_PIN_LO[15:2]);
        hit_pin_hi = (paddr[15:2] == ADR_PIN_HI[15:2]);
        hit_pin_misc = (paddr[15:2] == ADR_PIN_MISC[15:2]);
        // Status words are read-only; a write to them is refused
        hit_ro = hit_mcq || hit_pin_lo || hit_pin_hi || hit_pin_misc;
        rd_data = 32'h0000_0000;
        if (hit_term)
        begin
            if (paddr[2])
                rd_data = 32'(term_comp_ff[paddr[12:10]][paddr[9:3]]);
            else
                rd_data = 32'(term_true_ff[paddr[12:10]][paddr[9:3]]);
        end
        else if (hit_route)
            rd_data = 32'(route_ff[paddr[9:7]][paddr[6:2]]);
        else if (hit_mccfg)
            rd_data = 32'(mccfg_ff[paddr[8:6]][paddr[5:2]]);
        else if (hit_steer)
            rd_data = 32'(steer_ff[paddr[8:6]][paddr[5:2]]);
        else if (hit_mcq)
            rd_data = 32'(state_ff.q[paddr[4:2]]);
        else if (hit_pin_lo)
            rd_data = io_in[31:0];
        else if (hit_pin_hi)
            rd_data = io_in[63:32];
        else if (hit_pin_misc)
            rd_data = 32'({clk_pin, ded_in});
    end

    // ------------------------------------------------------------
    // Routing matrix and product terms
    // ------------------------------------------------------------
    always_comb
    begin
        int s;
        int f;
        int sb;
        int k;
        logic cs;
        s = 0;
        f = 0;
        sb = 0;
        k = 0;
        cs = 1'b0;
        // Pins always enter routing, driven or not
        src[NIO-1:0] = io_in;
        src[NIO+NDED-1:NIO] = ded_in;
        src[FB_BASE-1:NIO+NDED] = clk_pin;
        for (int b = 0; b < NBLK; b++)
        begin
            for (int m = 0; m < NMC; m++)
            begin
                // Feedback in every mode, after polarity
                src[FB_BASE + b*NMC + m] =
                    state_ff.q[b][m] ^ mccfg_ff[b][m].pol;
            end
        end
        for (int b = 0; b < NBLK; b++)
        begin
            for (int i = 0; i < NIN; i++)
            begin
                s = int'(route_ff[b][i]);
                blk_in[b][i] = 1'b0;
                if (s < FB_BASE)
                    blk_in[b][i] = src[s];
                else if (s < NSRC)
                begin
                    f = s - FB_BASE;
                    sb = f / NMC;
                    // Odd cells are buried; no far-block reach
                    if ((f % 2 == 0) || (sb == b) || (sb == NBLK-1-b))
                        blk_in[b][i] = src[s];
                end
            end
            for (int t = 0; t < NTERM; t++)
            begin
                // Unprogrammed term reads low
                pt[b][t] = (|(term_true_ff[b][t] | term_comp_ff[b][t]))
                    && ((blk_in[b] & term_true_ff[b][t])
                        == term_true_ff[b][t])
                    && ((~blk_in[b] & term_comp_ff[b][t])
                        == term_comp_ff[b][t]);
            end
            mc_sum[b] = '0;
            for (int c = 0; c < NCLU; c++)
            begin
                // Cluster c serves cells c-2..c+1 only
                cs = |pt[b][c*CLU_SZ +: CLU_SZ];
                k = c - 2 + int'(steer_ff[b][c]);
                if (k >= 0 && k < NMC)
                    mc_sum[b][k] = mc_sum[b][k] | cs;
            end
        end
    end

    // ------------------------------------------------------------
    // Macrocells, pin cells and bus answer
    // ------------------------------------------------------------
    always_comb
    begin
        plbf_mccfg_t cfg;
        logic d;
        logic edge_up;
        logic gate;
        cfg = '0;
        d = 1'b0;
        edge_up = 1'b0;
        gate = 1'b0;
        nxt_state = state_ff;
        nxt_state.clk_prev = clk_pin;
        for (int b = 0; b < NBLK; b++)
        begin
            for (int m = 0; m < NMC; m++)
            begin
                cfg = mccfg_ff[b][m];
                d = mc_sum[b][m];
                if ((m % 2 == 1) && cfg.inreg)
                    d = io_in[b*NPIN_BLK + m/2];
                // Per-cell clock choice
                edge_up = clk_pin[cfg.clk] & ~state_ff.clk_prev[cfg.clk];
                gate = clk_pin[cfg.clk];
                unique case (cfg.mode)
                    MODE_COMB: nxt_state.q[b][m] = d;
                    MODE_DFF:
                        if (edge_up)
                            nxt_state.q[b][m] = d;
                    MODE_TFF:
                        if (edge_up && d)
                            nxt_state.q[b][m] = ~state_ff.q[b][m];
                    MODE_LATCH:
                        if (!gate)
                            nxt_state.q[b][m] = d;
                endcase
                // Block-wide forcing, independent of the pin clock
                if (cfg.mode != MODE_COMB)
                begin
                    if (pt[b][PT_RST])
                        nxt_state.q[b][m] = 1'b0;
                    else if (pt[b][PT_SET])
                        nxt_state.q[b][m] = 1'b1;
                end
            end
            for (int i = 0; i < NPIN_BLK; i++)
            begin
                cfg = mccfg_ff[b][2*i];
                nxt_state.io_out[b*NPIN_BLK + i] =
                    nxt_state.q[b][2*i] ^ cfg.pol;
                unique case (cfg.oe)
                    OE_OFF: nxt_state.io_oe[b*NPIN_BLK + i] = 1'b0;
                    OE_ON: nxt_state.io_oe[b*NPIN_BLK + i] = 1'b1;
                    OE_PT0:
                        nxt_state.io_oe[b*NPIN_BLK + i] = pt[b][PT_OE0];
                    OE_PT1:
                        nxt_state.io_oe[b*NPIN_BLK + i] = pt[b][PT_OE1];
                endcase
            end
        end
        // One wait state keeps all bus outputs registered
        nxt_state.pready = psel & penable & ~state_ff.pready;
        if (psel && penable && !state_ff.pready)
        begin
            nxt_state.pslverr = (paddr[1:0] != 2'h0)
                || !(hit_term || hit_route || hit_mccfg || hit_steer
                     || hit_ro)
                || (pwrite && hit_ro);
            nxt_state.prdata = pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------
    // Everything resets to a blank device: terms low, pins undriven
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int b = 0; b < NBLK; b++)
            begin
                for (int t = 0; t < NTERM; t++)
                begin
                    term_true_ff[b][t] <= '0;
                    term_comp_ff[b][t] <= '0;
                end
                for (int i = 0; i < NIN; i++)
                    route_ff[b][i] <= 8'h00;
                for (int m = 0; m < NMC; m++)
                begin
                    mccfg_ff[b][m] <= '0;
                    steer_ff[b][m] <= 2'h0;
                end
            end
        end
        else if (wr_take && paddr[1:0] == 2'h0)
        begin
            if (hit_term && paddr[2])
                term_comp_ff[paddr[12:10]][paddr[9:3]] <= pwdata[NIN-1:0];
            else if (hit_term)
                term_true_ff[paddr[12:10]][paddr[9:3]] <= pwdata[NIN-1:0];
            else if (hit_route)
                route_ff[paddr[9:7]][paddr[6:2]] <= pwdata[7:0];
            else if (hit_mccfg)
                mccfg_ff[paddr[8:6]][paddr[5:2]] <=
                    plbf_mccfg_t'(pwdata[7:0]);
            else if (hit_steer)
                steer_ff[paddr[8:6]][paddr[5:2]] <= pwdata[1:0];
        end
    end

endmodule // plbf_fabric

// >>> shared/plbf_pkg.sv
// Constants and carrier types for the programmable logic fabric.
// Assumes one system clock; pins are synchronous to it.
package plbf_pkg;

    // ------------------------------------------------------------
    // Fabric dimensions
    // ------------------------------------------------------------
    localparam int NBLK = 8;
    localparam int NIN = 26;
    localparam int NLT = 64;
    localparam int NTERM = 68;
    localparam int NMC = 16;
    localparam int NCLU = 16;
    localparam int CLU_SZ = 4;
    localparam int NPIN_BLK = 8;
    localparam int NIO = 64;
    localparam int NDED = 2;
    localparam int NCLK = 4;
    localparam int FB_BASE = 70;
    localparam int NSRC = 198;

    // Special term slots after the logic terms
    localparam int PT_OE0 = 64;
    localparam int PT_OE1 = 65;
    localparam int PT_RST = 66;
    localparam int PT_SET = 67;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] ADR_TERM = 16'h0000;
    localparam logic [15:0] ADR_ROUTE = 16'h2000;
    localparam logic [15:0] ADR_MCCFG = 16'h2400;
    localparam logic [15:0] ADR_STEER = 16'h2600;
    localparam logic [15:0] ADR_MCQ = 16'h2800;
    localparam logic [15:0] ADR_PIN_LO = 16'h2820;
    localparam logic [15:0] ADR_PIN_HI = 16'h2824;
    localparam logic [15:0] ADR_PIN_MISC = 16'h2828;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_COMB = 2'h0;
    localparam logic [1:0] MODE_DFF = 2'h1;
    localparam logic [1:0] MODE_TFF = 2'h2;
    localparam logic [1:0] MODE_LATCH = 2'h3;
    localparam logic [1:0] OE_OFF = 2'h0;
    localparam logic [1:0] OE_ON = 2'h1;
    localparam logic [1:0] OE_PT0 = 2'h2;
    localparam logic [1:0] OE_PT1 = 2'h3;

    // Macrocell configuration word, bits [7:0]
    typedef struct packed {
        logic [1:0] oe;
        logic inreg;
        logic [1:0] clk;
        logic pol;
        logic [1:0] mode;
    } plbf_mccfg_t;

    // Sequential state of the fabric top, apart from its configuration memories
    typedef struct packed {
        logic [NBLK-1:0][NMC-1:0] q;
        logic [NCLK-1:0] clk_prev;
        logic [NIO-1:0] io_out;
        logic [NIO-1:0] io_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } plbf_state_t;

endpackage

// >>> verification/plbf_board.sv
// Board model: drives pins, clock pins and dedicated inputs.
// Assumes the bench sets the levels; an enabled fabric driver wins.
`timescale 1ns/10ps
module plbf_board
    import plbf_pkg::*;
(
    input wire logic [NIO-1:0] drv,
    input wire logic [NDED-1:0] ded_set,
    input wire logic [NCLK-1:0] clk_set,
    input wire logic [NIO-1:0] io_out,
    input wire logic [NIO-1:0] io_oe,
    output logic [NIO-1:0] io_in,
    output logic [NDED-1:0] ded_in,
    output logic [NCLK-1:0] clk_pin
);
    // Wire level: fabric driver where its enable is set, else the bench level
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    assign ded_in = ded_set;
    assign clk_pin = clk_set;
endmodule // plbf_board

// >>> verification/plbf_fabric_sva.sv
// Checker for the fabric's register port and pin outputs.
// Assumes it is bound to plbf_fabric and sees only its ports.
`timescale 1ns/10ps
module plbf_fabric_sva
    import plbf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NIO-1:0] io_in,
    input wire logic [NIO-1:0] io_out,
    input wire logic [NIO-1:0] io_oe,
    input wire logic [NDED-1:0] ded_in,
    input wire logic [NCLK-1:0] clk_pin
);
    // Counts edges with no input change and no psel; feedback needs a few to settle
    logic [3:0] quiet_ff;
    logic [3:0] nxt_quiet;
    logic [69:0] in_prev_ff;
    always_comb
    begin
        nxt_quiet = quiet_ff;
        if (in_prev_ff != {io_in, ded_in, clk_pin} || psel)
            nxt_quiet = 4'h0;
        else if (quiet_ff != 4'hf)
            nxt_quiet = quiet_ff + 4'h1;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            quiet_ff <= 4'h0;
            in_prev_ff <= '0;
        end
        else
        begin
            quiet_ff <= nxt_quiet;
            in_prev_ff <= {io_in, ded_in, clk_pin};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    AST_RDY_ANSWER: assert property (s_access |=> pready)
        else $error("pready late");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_RDY_CAUSE: assert property (pready |-> psel && $past(penable))
        else $error("pready without access");
    AST_ERR_TIMING: assert property ($changed(pslverr) |-> pready)
        else $error("pslverr moved outside answer");
    AST_DATA_TIMING: assert property ($changed(prdata) |-> pready)
        else $error("prdata moved outside answer");
    AST_RST_VALUES: assert property ($fell(rst) |-> !pready && !pslverr
        && io_oe == '0 && io_out == '0 && prdata == '0)
        else $error("outputs not cleared by reset");
    AST_MISALIGN: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    AST_RO_WRITE: assert property (pready && pwrite && paddr == ADR_MCQ
        |-> pslverr) else $error("read-only write accepted");
    AST_PINS_QUIET: assert property (quiet_ff >= 4'h8 |->
        $stable(io_out) && $stable(io_oe)) else $error("pins moved");
endmodule // plbf_fabric_sva

bind plbf_fabric plbf_fabric_sva plbf_fabric_sva_inst (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .ded_in(ded_in), .clk_pin(clk_pin));

// >>> verification/plbf_fabric_tb.sv
// Bench: APB setup of block 0, then D, T, latch, polarity,
// clock select, reset/preset and pin enable checks on pin 0.
// Assumes plbf_board for pin levels and the bound checker.
`timescale 1ns/10ps
module plbf_fabric_tb
    import plbf_pkg::*;
;
    typedef struct packed {logic rd; logic err; logic [31:0] d;} plbf_note_t;
    // In0=pin 8, in1=ded0, in2=ded1, in3=clock pin 1
    localparam logic [15:0] CFG_A [11] = '{16'h2000, 16'h2004, 16'h2008,
        16'h200c, 16'h0000, 16'h0200, 16'h020c, 16'h0210, 16'h0218,
        16'h2600, 16'h2400};
    localparam logic [7:0] CFG_D [11] = '{8'h08, 8'h40, 8'h41, 8'h43,
        8'h01, 8'h08, 8'h08, 8'h02, 8'h04, 8'h02, 8'h41};
    localparam logic [1:0] OE_EXP [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    // Buried cell 1 of block 0 routed to sibling block 7 and to block 1
    localparam logic [15:0] CFG2_A [6] = '{16'h2380, 16'h2080, 16'h1c00,
        16'h0400, 16'h27c0, 16'h2640};
    localparam logic [7:0] CFG2_D [6] = '{8'h47, 8'h47, 8'h01, 8'h01,
        8'h02, 8'h02};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, exp;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [NIO-1:0] io_in, io_out, io_oe, drv = 64'h0;
    logic [NDED-1:0] ded_in, ded_set = 2'h0;
    logic [NCLK-1:0] clk_pin, clk_set = 4'h0;
    int errors = 0, comparisons = 0, seed = 39934;
    plbf_note_t notes[$];
    plbf_note_t note;
    plbf_fabric plbf_fabric_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .ded_in(ded_in), .clk_pin(clk_pin));
    plbf_board plbf_board_inst (.drv(drv), .ded_set(ded_set),
        .clk_set(clk_set), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
        .ded_in(ded_in), .clk_pin(clk_pin));
    initial
        forever #2.5 clk_sys = ~clk_sys;
    task automatic check(input string what, input logic [31:0] want,
        input logic [31:0] got);
        comparisons++;
        if (got !== want)
        begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, want, got);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d, input logic e);
        notes.push_back('{!w && !e, e, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Waits as long as it takes; only the watchdog ends a hang
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so back-to-back calls never assign twice at once
        @(posedge clk_sys);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic pulse_clk(input int k);
        clk_set[k] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        clk_set[k] <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic pin(input logic want);
        check("pin 0", {31'h0, want}, {31'h0, io_out[0]});
    endtask
    always @(posedge clk_sys)
        if (pready === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            check("pslverr", {31'h0, note.err}, {31'h0, pslverr});
            if (note.rd)
                check("prdata", note.d, prdata);
        end
    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        drv <= {$random(seed), $random(seed)};
        settle();
        apb(1'b0, ADR_PIN_LO, drv[31:0], 1'b0);
        apb(1'b0, 16'h2802, 32'h0, 1'b1);
        apb(1'b1, ADR_MCQ, 32'h0000_ffff, 1'b1);
        apb(1'b0, 16'h3000, 32'h0, 1'b1);
        for (int i = 0; i < 11; i++)
            apb(1'b1, CFG_A[i], {24'h0, CFG_D[i]}, 1'b0);
        // Comb phase may have loaded the random pin; reset term clears it
        ded_set <= 2'h1;
        settle();
        ded_set <= 2'h0;
        apb(1'b0, ADR_MCQ, 32'h0, 1'b0);
        exp = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            drv[8] <= 1'($random(seed));
            settle();
            pin(exp);
            pulse_clk(0);
            exp = drv[8];
            pin(exp);
        end
        apb(1'b1, ADR_MCCFG, 32'h42, 1'b0);
        drv[8] <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            pulse_clk(0);
            exp = ~exp;
            pin(exp);
        end
        drv[8] <= 1'b0;
        pulse_clk(0);
        pin(exp);
        apb(1'b1, ADR_MCCFG, 32'h43, 1'b0);
        settle();
        pin(1'b0);
        drv[8] <= 1'b1;
        settle();
        pin(1'b1);
        clk_set[0] <= 1'b1;
        settle();
        drv[8] <= 1'b0;
        settle();
        pin(1'b1);
        clk_set[0] <= 1'b0;
        settle();
        pin(1'b0);
        apb(1'b1, ADR_MCCFG, 32'h44, 1'b0);
        settle();
        pin(1'b1);
        apb(1'b1, ADR_MCCFG, 32'h51, 1'b0);
        drv[8] <= 1'b1;
        pulse_clk(0);
        pin(1'b0);
        pulse_clk(2);
        pin(1'b1);
        apb(1'b1, ADR_MCCFG, 32'h41, 1'b0);
        drv[8] <= 1'b0;
        pulse_clk(0);
        ded_set <= 2'h2;
        settle();
        pin(1'b1);
        apb(1'b0, ADR_MCQ, 32'h1, 1'b0);
        ded_set <= 2'h3;
        settle();
        pin(1'b0);
        ded_set <= 2'h0;
        for (int o = 0; o < 4; o++)
            for (int c = 0; c < 2; c++)
            begin
                apb(1'b1, ADR_MCCFG, {24'h0, o[1:0], 6'h01}, 1'b0);
                clk_set[1] <= c[0];
                settle();
                check("pin 0 enable", {31'h0, OE_EXP[o][c]},
                    {31'h0, io_oe[0]});
            end
        // Pin 0 undriven now; buried cell 1 registers it on clock pin 0
        drv[0] <= 1'b1;
        apb(1'b1, 16'h2404, 32'h21, 1'b0);
        pulse_clk(0);
        apb(1'b0, ADR_MCQ, 32'h2, 1'b0);
        for (int i = 0; i < 6; i++)
            apb(1'b1, CFG2_A[i], {24'h0, CFG2_D[i]}, 1'b0);
        settle();
        apb(1'b0, 16'h281c, 32'h1, 1'b0);
        apb(1'b0, 16'h2804, 32'h0, 1'b0);
        settle();
        complete_run();
    end
endmodule // plbf_fabric_tb
